// file: core/flash_sec_pkg.sv
package flash_sec_pkg;
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFF_OPTION = 8'h00;
    localparam logic [APB_AW-1:0] OFF_CONFIG = 8'h04;
    localparam logic [APB_AW-1:0] OFF_PROT = 8'h08;
    localparam logic [APB_AW-1:0] OFF_STATUS = 8'h0C;
    localparam logic [APB_AW-1:0] OFF_CMD = 8'h10;
    localparam logic [APB_AW-1:0] OFF_TARGET = 8'h14;
    localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
    localparam int OPT_NORED_BIT = 6;
    localparam int CFG_KEY_WRITE_STEER_BIT = 5;
    localparam int PROT_DIS_BIT = 0;
    localparam int PROT_SEL_LSB = 1;
    localparam int ST_CBEF_BIT = 7;
    localparam int ST_CCF_BIT = 6;
    localparam int ST_PVIOL_BIT = 5;
    localparam int ST_BLANK_BIT = 2;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [15:0] KEY_BASE = 16'hFFB0;
    localparam int KEY_BYTES = 8;
    localparam int KEY_IDX_W = 3;
    localparam int GRANULE_SHIFT = 9;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_PROG = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    typedef enum logic [1:0] {
        cmd_idle, cmd_loaded, cmd_coded, cmd_busy
    } cmd_state_t;
endpackage

// file: core/flash_sec_prot.sv
// Functional notes
// RL1: reset loads option shadow from nonvolatile byte
// RL2: shadow changes only by reprogram plus reset
// RL3: key disabled means key attempts ignored
// RL4: matching ascending 8-byte key unlocks until reset
// RL5: key writes from debug commands are rejected
// RL6: redirect-disable bit set turns redirection off
// RL7: only code 1:0 means unsecured
// RL8: secure blocks unsecured memory accesses
// RL9: key match or blank pass forces 1:0
// RL10: steer clear makes key writes command writes
// RL11: steer set captures key range as key
// RL12: reset loads protection shadow from nonvolatile byte
// RL13: protection readable, user writes have no effect
// RL14: debug commands may change protection bits
// RL15: select field sets unprotected region upper end
// RL16: erase or program in protected region refused
// RL17: disable bit set leaves whole flash open
// RL18: protected command ignored, sticky flag, write-1 clear
// RL19: clearing steer after eight bytes compares key
// RL20: firmware writes key ascending, never back to back
// RL21: select decode in 512-byte granules
`timescale 1ns/10ps
module flash_sec_prot
    import flash_sec_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [flash_sec_pkg::APB_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic apb_debug_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [7:0] option_nonvolatile_byte_in,
    input wire logic [7:0] protection_nonvolatile_byte_in,
    input wire logic [63:0] stored_backdoor_key_in,
    input wire logic flash_wr_in,
    input wire logic [15:0] flash_addr_in,
    input wire logic [7:0] flash_data_in,
    input wire logic flash_wr_debug_in,
    input wire logic cmd_done_in,
    input wire logic blank_result_in,
    output logic cmd_launch_out,
    output logic [7:0] cmd_code_out,
    output logic [15:0] cmd_addr_out,
    output logic [7:0] cmd_data_out,
    output logic secure_out,
    output logic block_unsecured_access_out,
    output logic vector_redirect_en_out,
    output logic key_unlocked_out
);
    import flash_sec_pkg::*;

    logic [7:0] option_shadow_reg_r;
    logic [1:0] security_code_r;
    logic [7:0] flash_config_reg_r;
    logic [7:0] protection_shadow_reg_r;
    logic [7:0] cmd_code_r;
    logic command_buffer_empty_flag_r;
    logic cmd_complete_r;
    logic protection_violation_flag_r;
    logic blank_flag_r;
    cmd_state_t cmd_state_r;
    cmd_state_t cmd_state_nxt;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic cmd_launch_r;
    logic [15:0] cmd_addr_r;
    logic [7:0] cmd_data_r;
    logic secure_r;
    logic redirect_en_r;
    logic unlocked_r;
    logic backdoor_key_enable;
    logic key_write_steer;
    logic [6:0] protect_boundary_select;
    logic protection_disable;
    logic apb_access;
    logic apb_wr;
    logic mapped;
    logic in_key_range;
    logic flash_wr_ok;
    logic key_wr;
    logic cmd_wr;
    logic steer_clear;
    logic steer_set;
    logic key_match;
    logic launch_req;
    logic target_protected;
    logic is_erase_prog;
    logic whole_array;
    logic secure_now;

    assign backdoor_key_enable = option_shadow_reg_r[OPT_BACKDOOR_KEY_ENABLE_BIT];
    assign key_write_steer = flash_config_reg_r[CFG_KEY_WRITE_STEER_BIT];
    assign protect_boundary_select = protection_shadow_reg_r[7:PROT_SEL_LSB];
    assign protection_disable = protection_shadow_reg_r[PROT_DIS_BIT];
    assign secure_now = security_code_r != SEC_UNSECURED; // RL7

    // apb answers on the second access cycle
    assign apb_access = psel_in && penable_in && !pready_r;
    assign apb_wr = apb_access && pwrite_in;
    assign mapped = paddr_in == OFF_OPTION || paddr_in == OFF_CONFIG ||
        paddr_in == OFF_PROT || paddr_in == OFF_STATUS ||
        paddr_in == OFF_CMD || paddr_in == OFF_TARGET;
    assign in_key_range = flash_addr_in[15:KEY_IDX_W] ==
        KEY_BASE[15:KEY_IDX_W];
    // debug writes cannot reach memory while secure
    assign flash_wr_ok = flash_wr_in &&
        !(flash_wr_debug_in && secure_now); // RL8
    // key capture path only with steer set and key enabled
    assign key_wr = flash_wr_ok && in_key_range && key_write_steer &&
        backdoor_key_enable && !flash_wr_debug_in; // RL3 RL5 RL11
    assign cmd_wr = flash_wr_ok && !(in_key_range && key_write_steer); // RL10

    assign steer_set = apb_wr && paddr_in == OFF_CONFIG &&
        !apb_debug_in && pwdata_in[CFG_KEY_WRITE_STEER_BIT] && !key_write_steer;
    assign steer_clear = apb_wr && paddr_in == OFF_CONFIG &&
        !pwdata_in[CFG_KEY_WRITE_STEER_BIT] && key_write_steer;

    assign launch_req = apb_wr && paddr_in == OFF_STATUS &&
        pwdata_in[ST_CBEF_BIT] && cmd_state_r == cmd_coded;
    assign is_erase_prog = cmd_code_r == CMD_PROG ||
        cmd_code_r == CMD_BURST || cmd_code_r == CMD_PAGE_ERASE ||
        cmd_code_r == CMD_MASS_ERASE;
    assign whole_array = cmd_code_r == CMD_MASS_ERASE;

    prot_region u_region (
        .boundary_sel_in(protect_boundary_select),
        .disable_in(protection_disable),
        .addr_in(cmd_addr_r),
        .whole_array_in(whole_array),
        .protected_out(target_protected)
    );

    key_compare u_key (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .restart_in(steer_set),
        .wr_in(key_wr),
        .idx_in(flash_addr_in[KEY_IDX_W-1:0]),
        .data_in(flash_data_in),
        .stored_key_in(stored_backdoor_key_in),
        .check_in(steer_clear && backdoor_key_enable), // RL3 RL19
        .match_out(key_match)
    );

    // shadow loads happen while reset is held
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            option_shadow_reg_r <= option_nonvolatile_byte_in; // RL1 RL2
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            security_code_r <= option_nonvolatile_byte_in[1:0]; // RL1
        end else if (key_match) begin
            security_code_r <= SEC_UNSECURED; // RL4 RL9
        end else if (cmd_done_in && cmd_state_r == cmd_busy &&
                     cmd_code_r == CMD_BLANK && blank_result_in) begin
            security_code_r <= SEC_UNSECURED; // RL9
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            protection_shadow_reg_r <= protection_nonvolatile_byte_in; // RL12
        end else if (apb_wr && paddr_in == OFF_PROT && apb_debug_in) begin
            protection_shadow_reg_r <= pwdata_in[7:0]; // RL13 RL14
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            flash_config_reg_r <= CONFIG_RESET;
        end else if (apb_wr && paddr_in == OFF_CONFIG) begin
            flash_config_reg_r <= pwdata_in[7:0] &
                (8'h01 << CFG_KEY_WRITE_STEER_BIT);
        end
    end

    // command sequence: array write, code, launch
    always_comb begin
        cmd_state_nxt = cmd_state_r;
        case (cmd_state_r)
            cmd_idle: begin
                if (cmd_wr) begin
                    cmd_state_nxt = cmd_loaded; // RL10
                end
            end
            cmd_loaded: begin
                if (apb_wr && paddr_in == OFF_CMD) begin
                    cmd_state_nxt = cmd_coded;
                end
            end
            cmd_coded: begin
                if (launch_req) begin
                    if (is_erase_prog && target_protected) begin
                        cmd_state_nxt = cmd_idle; // RL16 RL18
                    end else begin
                        cmd_state_nxt = cmd_busy;
                    end
                end
            end
            cmd_busy: begin
                if (cmd_done_in) begin
                    cmd_state_nxt = cmd_idle;
                end
            end
            default: begin
                cmd_state_nxt = cmd_idle;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cmd_state_r <= cmd_idle;
        end else begin
            cmd_state_r <= cmd_state_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cmd_addr_r <= '0;
            cmd_data_r <= '0;
        end else if (cmd_wr && cmd_state_r == cmd_idle) begin
            cmd_addr_r <= flash_addr_in;
            cmd_data_r <= flash_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cmd_code_r <= CMD_RESET;
        end else if (apb_wr && paddr_in == OFF_CMD &&
                     cmd_state_r == cmd_loaded) begin
            cmd_code_r <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cmd_launch_r <= 1'b0;
        end else begin
            cmd_launch_r <= launch_req &&
                !(is_erase_prog && target_protected); // RL16
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            command_buffer_empty_flag_r <= 1'b1;
            cmd_complete_r <= 1'b1;
        end else if (launch_req &&
                     !(is_erase_prog && target_protected)) begin
            command_buffer_empty_flag_r <= 1'b0;
            cmd_complete_r <= 1'b0;
        end else if (cmd_done_in && cmd_state_r == cmd_busy) begin
            command_buffer_empty_flag_r <= 1'b1;
            cmd_complete_r <= 1'b1;
        end
    end

    // sticky; a new violation beats a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            protection_violation_flag_r <= 1'b0;
        end else if (launch_req && is_erase_prog && target_protected) begin
            protection_violation_flag_r <= 1'b1; // RL18
        end else if (apb_wr && paddr_in == OFF_STATUS &&
                     pwdata_in[ST_PVIOL_BIT]) begin
            protection_violation_flag_r <= 1'b0; // RL18
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            blank_flag_r <= 1'b0;
        end else if (launch_req) begin
            blank_flag_r <= 1'b0;
        end else if (cmd_done_in && cmd_state_r == cmd_busy &&
                     cmd_code_r == CMD_BLANK) begin
            blank_flag_r <= blank_result_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            secure_r <= 1'b1;
            unlocked_r <= 1'b0;
        end else begin
            secure_r <= secure_now; // RL7 RL8
            unlocked_r <= unlocked_r || key_match; // RL4
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            redirect_en_r <= 1'b0;
        end else begin
            redirect_en_r <= !option_shadow_reg_r[OPT_NORED_BIT]; // RL6
        end
    end

    // apb slave: one wait state, error on unmapped address
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_access;
            pslverr_r <= apb_access && !mapped;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            prdata_r <= '0;
        end else if (apb_access && !pwrite_in) begin
            case (paddr_in)
                OFF_OPTION: begin
                    prdata_r <= {24'h0000_00,
                        option_shadow_reg_r[7:2], security_code_r};
                end
                OFF_CONFIG: begin
                    prdata_r <= {24'h0000_00, flash_config_reg_r};
                end
                OFF_PROT: begin
                    prdata_r <= {24'h0000_00, protection_shadow_reg_r}; // RL13
                end
                OFF_STATUS: begin
                    prdata_r <= '0;
                    prdata_r[ST_CBEF_BIT] <= command_buffer_empty_flag_r;
                    prdata_r[ST_CCF_BIT] <= cmd_complete_r;
                    prdata_r[ST_PVIOL_BIT] <= protection_violation_flag_r;
                    prdata_r[ST_BLANK_BIT] <= blank_flag_r;
                end
                OFF_CMD: begin
                    prdata_r <= {24'h0000_00, cmd_code_r};
                end
                OFF_TARGET: begin
                    prdata_r <= {16'h0000, cmd_addr_r};
                end
                default: begin
                    prdata_r <= '0;
                end
            endcase
        end else begin
            prdata_r <= '0;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign cmd_launch_out = cmd_launch_r;
    assign cmd_code_out = cmd_code_r;
    assign cmd_addr_out = cmd_addr_r;
    assign cmd_data_out = cmd_data_r;
    assign secure_out = secure_r;
    assign block_unsecured_access_out = secure_r; // RL8
    assign vector_redirect_en_out = redirect_en_r;
    assign key_unlocked_out = unlocked_r;
endmodule

// file: core/key_compare.sv
`timescale 1ns/10ps
module key_compare
    import flash_sec_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic restart_in,
    input wire logic wr_in,
    input wire logic [flash_sec_pkg::KEY_IDX_W-1:0] idx_in,
    input wire logic [7:0] data_in,
    input wire logic [8*flash_sec_pkg::KEY_BYTES-1:0] stored_key_in,
    input wire logic check_in,
    output logic match_out
);
    import flash_sec_pkg::*;
    logic [7:0] cap_r [KEY_BYTES];
    logic [KEY_IDX_W:0] count_r;
    logic order_ok_r;
    logic [KEY_BYTES-1:0] eq;

    genvar g;
    generate
        for (g = 0; g < KEY_BYTES; g++) begin : g_eq
            assign eq[g] = cap_r[g] == stored_key_in[8*g +: 8];
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!nrst_in || restart_in) begin
            count_r <= '0;
            order_ok_r <= 1'b1;
        end else if (wr_in) begin
            // bytes must arrive in ascending order
            if ({1'b0, idx_in} != count_r) begin
                order_ok_r <= 1'b0; // RL4
            end
            if (count_r != (KEY_IDX_W+1)'(KEY_BYTES)) begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            cap_r[idx_in] <= data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            match_out <= 1'b0;
        end else begin
            match_out <= check_in && order_ok_r && &eq && // RL19
                count_r == (KEY_IDX_W+1)'(KEY_BYTES);
        end
    end
endmodule

// file: core/prot_region.sv
`timescale 1ns/10ps
module prot_region
    import flash_sec_pkg::*;
(
    input wire logic [6:0] boundary_sel_in,
    input wire logic disable_in,
    input wire logic [15:0] addr_in,
    input wire logic whole_array_in,
    output logic protected_out
);
    import flash_sec_pkg::*;
    logic [6:0] granule;
    assign granule = addr_in[15:GRANULE_SHIFT];
    // high end above the selected granule is locked
    assign protected_out = !disable_in && // RL17
        (whole_array_in || granule > boundary_sel_in); // RL15 RL21
endmodule

// file: testbench/flash_array_model.sv
`timescale 1ns/10ps
module flash_array_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic launch_in,
    input wire logic erased_in,
    output logic done_out,
    output logic blank_result_out
);
    logic [3:0] busy_r;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            busy_r <= 4'h0;
        end else if (launch_in) begin
            busy_r <= 4'h5;
        end else if (busy_r != 4'h0) begin
            busy_r <= busy_r - 4'h1;
        end
    end

    // result line only meaningful with done; scrambled otherwise
    always_ff @(posedge clk_in) begin
        done_out <= nrst_in && busy_r == 4'h1;
        if (busy_r == 4'h1) begin
            blank_result_out <= erased_in;
        end else begin
            blank_result_out <= ~blank_result_out;
        end
    end
endmodule

// file: testbench/flash_sec_prot_props.sv
`timescale 1ns/10ps
module flash_sec_prot_props
    import flash_sec_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [flash_sec_pkg::APB_AW-1:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic cmd_launch_out,
    input wire logic secure_out,
    input wire logic block_unsecured_access_out,
    input wire logic vector_redirect_en_out,
    input wire logic key_unlocked_out
);
    import flash_sec_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_ready_after_take: assert property (
        psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready missing after access");
    a_ready_one_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 0)
        else $error("read data not zero when idle");
    a_block_mirror: assert property (
        block_unsecured_access_out == secure_out)
        else $error("access block differs from secure");
    a_secure_no_rise: assert property (
        $rose(secure_out) |-> !$past(nrst_in))
        else $error("secure rose outside reset");
    a_redirect_fixed: assert property (
        nrst_in && $past(nrst_in) && $past(nrst_in, 2)
        |-> $stable(vector_redirect_en_out))
        else $error("redirect changed outside reset");
    a_unlock_sticky: assert property (
        key_unlocked_out |=> key_unlocked_out)
        else $error("unlock dropped before reset");
    a_unlock_opens: assert property (
        $rose(key_unlocked_out) |-> ##[0:3] !secure_out)
        else $error("unlock did not clear secure");
    a_launch_cause: assert property (
        cmd_launch_out |-> $past(psel_in && penable_in && pwrite_in
        && paddr_in == OFF_STATUS))
        else $error("launch without status write");
    c_unlock: cover property ($rose(key_unlocked_out));
    c_launch: cover property (cmd_launch_out);
    c_error: cover property (pslverr_out);
endmodule

bind flash_sec_prot flash_sec_prot_props chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .cmd_launch_out(cmd_launch_out),
    .secure_out(secure_out),
    .block_unsecured_access_out(block_unsecured_access_out),
    .vector_redirect_en_out(vector_redirect_en_out),
    .key_unlocked_out(key_unlocked_out));

// file: testbench/flash_sec_prot_tb.sv
`timescale 1ns/10ps
module flash_sec_prot_tb;
    import flash_sec_pkg::*;
    typedef struct packed {
        logic [7:0] opt;
        logic [7:0] prot;
        logic sec;
        logic red;
    } row_t;
    localparam logic [63:0] KEY = 64'h8877_6655_4433_2211;
    localparam row_t ROWS [4] = '{
        '{8'h80, 8'hFC, 1'b1, 1'b1}, '{8'h41, 8'h01, 1'b1, 1'b0},
        '{8'h02, 8'hA4, 1'b0, 1'b1}, '{8'hC3, 8'hFF, 1'b1, 1'b0}};
    logic clk_in = 0;
    logic nrst_in = 0;
    logic psel_in = 0;
    logic penable_in = 0;
    logic pwrite_in = 0;
    logic [APB_AW-1:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0;
    logic apb_debug_in = 0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, cmd_launch_out, secure_out;
    logic block_unsecured_access_out, vector_redirect_en_out;
    logic key_unlocked_out, cmd_done_in, blank_result_in;
    logic [7:0] opt_nv = 8'h80;
    logic [7:0] prot_nv = 8'hFC;
    logic flash_wr_in = 0;
    logic [15:0] flash_addr_in = '0;
    logic [7:0] flash_data_in = '0;
    logic flash_wr_debug_in = 0;
    logic erased = 0;
    logic [7:0] cmd_code_out, cmd_data_out, rd;
    logic [15:0] cmd_addr_out;
    logic er;
    int failures = 0;
    int checks = 0;
    int launches = 0;

    flash_sec_prot uut (.clk_in(clk_in), .nrst_in(nrst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .apb_debug_in(apb_debug_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .option_nonvolatile_byte_in(opt_nv),
        .protection_nonvolatile_byte_in(prot_nv),
        .stored_backdoor_key_in(KEY), .flash_wr_in(flash_wr_in),
        .flash_addr_in(flash_addr_in), .flash_data_in(flash_data_in),
        .flash_wr_debug_in(flash_wr_debug_in), .cmd_done_in(cmd_done_in),
        .blank_result_in(blank_result_in), .cmd_launch_out(cmd_launch_out),
        .cmd_code_out(cmd_code_out), .cmd_addr_out(cmd_addr_out),
        .cmd_data_out(cmd_data_out), .secure_out(secure_out),
        .block_unsecured_access_out(block_unsecured_access_out),
        .vector_redirect_en_out(vector_redirect_en_out),
        .key_unlocked_out(key_unlocked_out));
    flash_array_model arr (.clk_in(clk_in), .nrst_in(nrst_in),
        .launch_in(cmd_launch_out), .erased_in(erased),
        .done_out(cmd_done_in), .blank_result_out(blank_result_in));

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (cmd_launch_out === 1'b1) launches++;

    task automatic complete_run();
        if (failures == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t byte %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t flag %b want %b", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] d, input logic dbg);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= 32'(d);
        apb_debug_in <= dbg;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) chk_bit(1'b0, 1'b1);
        rd = prdata_out[7:0];
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // one idle cycle between writes keeps key bytes apart
    task automatic fwr(input logic [15:0] a, input logic [7:0] d,
        input logic dbg);
        @(posedge clk_in);
        flash_wr_in <= 1'b1;
        flash_addr_in <= a;
        flash_data_in <= d;
        flash_wr_debug_in <= dbg;
        @(posedge clk_in);
        flash_wr_in <= 1'b0;
    endtask

    task automatic rst(input logic [7:0] o, input logic [7:0] p);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        opt_nv <= o;
        prot_nv <= p;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic key_try(input logic dbg);
        apb(1'b1, OFF_CONFIG, 8'h20, 1'b0);
        for (int k = 0; k < KEY_BYTES; k++) begin
            fwr(KEY_BASE + 16'(k), KEY[8*k+:8], dbg);
        end
        apb(1'b1, OFF_CONFIG, 8'h00, 1'b0);
        repeat (3) @(posedge clk_in);
    endtask

    task automatic run_cmd(input logic [15:0] a, input logic [7:0] c);
        fwr(a, 8'h5A, 1'b0);
        apb(1'b1, OFF_CMD, c, 1'b0);
        apb(1'b1, OFF_STATUS, 8'h80, 1'b0);
        repeat (10) @(posedge clk_in);
    endtask

    initial begin
        #200000;
        failures++;
        complete_run();
    end

    initial begin
        foreach (ROWS[i]) begin
            rst(ROWS[i].opt, ROWS[i].prot);
            chk_bit(secure_out, ROWS[i].sec);
            chk_bit(vector_redirect_en_out, ROWS[i].red);
            chk_bit(block_unsecured_access_out, ROWS[i].sec);
            apb(1'b0, OFF_OPTION, 8'h00, 1'b0);
            chk_byte(rd, ROWS[i].opt);
            apb(1'b0, OFF_PROT, 8'h00, 1'b0);
            chk_byte(rd, ROWS[i].prot);
        end
        rst(8'h80, 8'hFC);
        apb(1'b1, OFF_OPTION, 8'h02, 1'b0);
        apb(1'b0, OFF_OPTION, 8'h00, 1'b0);
        chk_byte(rd, 8'h80);
        apb(1'b1, OFF_PROT, 8'hFF, 1'b0);
        apb(1'b0, OFF_PROT, 8'h00, 1'b0);
        chk_byte(rd, 8'hFC);
        apb(1'b1, 8'h18, 8'hFF, 1'b0);
        chk_bit(er, 1'b1);
        apb(1'b1, OFF_CONFIG, 8'hFF, 1'b0);
        apb(1'b0, OFF_CONFIG, 8'h00, 1'b0);
        chk_byte(rd, 8'h20);
        apb(1'b1, OFF_CONFIG, 8'h00, 1'b0);
        run_cmd(16'hFFB0, CMD_PROG);
        chk_byte(cmd_addr_out[15:8], 8'hFF);
        chk_byte(cmd_addr_out[7:0], 8'hB0);
        chk_byte(cmd_code_out, CMD_PROG);
        chk_byte(cmd_data_out, 8'h5A);
        apb(1'b0, OFF_STATUS, 8'h00, 1'b0);
        chk_bit(rd[ST_PVIOL_BIT], 1'b1);
        chk_byte(8'(launches), 8'h00);
        apb(1'b1, OFF_STATUS, 8'h20, 1'b0);
        apb(1'b0, OFF_STATUS, 8'h00, 1'b0);
        chk_bit(rd[ST_PVIOL_BIT], 1'b0);
        run_cmd(16'h8000, CMD_MASS_ERASE);
        chk_byte(8'(launches), 8'h00);
        apb(1'b1, OFF_STATUS, 8'h20, 1'b0);
        run_cmd(16'hFDFF, CMD_PAGE_ERASE);
        chk_byte(8'(launches), 8'h01);
        key_try(1'b1);
        chk_bit(secure_out, 1'b1);
        key_try(1'b0);
        chk_bit(key_unlocked_out, 1'b1);
        chk_bit(secure_out, 1'b0);
        apb(1'b0, OFF_OPTION, 8'h00, 1'b0);
        chk_byte(rd, 8'h82);
        rst(8'h82, 8'hFC);
        key_try(1'b1);
        chk_bit(key_unlocked_out, 1'b0);
        rst(8'h00, 8'hFC);
        key_try(1'b0);
        chk_bit(secure_out, 1'b1);
        apb(1'b1, OFF_PROT, 8'h01, 1'b1);
        apb(1'b0, OFF_PROT, 8'h00, 1'b0);
        chk_byte(rd, 8'h01);
        erased <= 1'b1;
        run_cmd(16'h8000, CMD_BLANK);
        chk_bit(secure_out, 1'b0);
        apb(1'b0, OFF_STATUS, 8'h00, 1'b0);
        chk_bit(rd[ST_BLANK_BIT], 1'b1);
        run_cmd(16'hFFB0, CMD_PROG);
        chk_byte(8'(launches), 8'h03);
        complete_run();
    end
endmodule
